// File: rtl/adr_pkg.sv
// constants for the amplifier diagnostic register bank
package adr_pkg;
   localparam logic [6:0] I2C_DEV_ADDR   = 7'h6c;
   localparam logic [7:0] OFS_FAULT      = 8'h01;
   localparam logic [7:0] OFS_STATUS     = 8'h02;
   localparam logic [7:0] OFS_CONTROL    = 8'h03;
   localparam logic [7:0] RST_FAULT      = 8'h00;
   localparam logic [7:0] RST_STATUS     = 8'h00;
   localparam logic [7:0] RST_CONTROL    = 8'h78;
   localparam logic [7:0] FAULT_RSVD_MSK = 8'h03;
   localparam logic [7:0] CTRL_WR_MSK    = 8'hf9;
   localparam int         BIT_FREQ       = 0;
   localparam int         LIM_LSB        = 3;
   localparam int         GAIN_LSB       = 6;
   localparam int         FLT_DIAG       = 2;
   localparam int         FLT_OC         = 3;
   localparam int         FLT_UV         = 4;
   localparam int         FLT_OV         = 5;
   localparam int         FLT_DC         = 6;
   localparam int         FLT_OT         = 7;
   localparam int         ST_FAULT       = 4;
   localparam int         ST_DIAG        = 5;
   localparam int         ST_MUTE        = 6;
   localparam int         ST_PLAY        = 7;
   localparam logic [2:0] LIM_OFF        = 3'b111;
   typedef enum logic [2:0]
   {
      ADR_IDLE = 3'b000,
      ADR_DEV  = 3'b001,
      ADR_SUB  = 3'b010,
      ADR_WDAT = 3'b011,
      ADR_RDAT = 3'b100,
      ADR_ACK  = 3'b101,
      ADR_RACK = 3'b110,
      ADR_SKIP = 3'b111
   } adr_state_t;
endpackage

// File: rtl/adr_sync.sv
// two-flop synchroniser with edge outputs taken after the second stage
`timescale 1ns/1ps
module adr_sync
(
   input  wire logic clk_sys,
   input  wire logic srst,
   input  wire logic ce,
   input  wire logic din,
   output logic      dout,
   output logic      rise,
   output logic      fall
);
   logic meta_r;
   logic sync_r;
   logic last_r;

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         last_r <= 1'b1;
      end
      else if (ce)
      begin
         meta_r <= din;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign dout = sync_r;
   assign rise = ce & sync_r & ~last_r;
   assign fall = ce & ~sync_r & last_r;
endmodule

// File: rtl/adr_fault_latch.sv
// sticky fault bits, set wins over clear
`timescale 1ns/1ps
module adr_fault_latch #(parameter int W = 6)
(
   input  wire logic         clk_sys,
   input  wire logic         srst,
   input  wire logic         ce,
   input  wire logic [W-1:0] ev,
   input  wire logic         clr,
   output logic [W-1:0]      q
);
   if (W < 1)
   begin : g_bad_width
      $error("fault latch width must be positive");
   end

   for (genvar i = 0; i < W; i++)
   begin : g_bit
      logic bit_r;
      always_ff @(posedge clk_sys)
      begin
         if (srst)
            bit_r <= 1'b0;
         else if (ce)
            bit_r <= ev[i] | (bit_r & ~clr);
      end
      assign q[i] = bit_r;
   end
endmodule

// File: rtl/adr_regs.sv
// two-wire serial slave with fault, status and control registers
// What this block does
// - decode fault 01, status 02, control 03
// - fault register resets zero, D1:D0 reserved
// - D2 load-diag fault, D3 overcurrent
// - D4 undervoltage, D5 overvoltage
// - D6 dc offset, D7 overtemperature
// - status resets zero, reads 80 (D7 play) once unmuted
// - D0 short to rail, D1 short ground
// - D2 open load, D3 shorted load
// - D4 fault, D5 diag, D6 mute, D7 play
// - control D7:D6 select gain
// - control D0 selects switching frequency
// - control D5:D3 set peak limiter
// - limiter disabled at reset, code 111
// - defaults serve when no master present
// - fault pin low when outputs hi-z
// - mute input stops switching, blocks audio
// - sequential read auto-increments address
// - open-load clears at next diagnostic cycle
`timescale 1ns/1ps
module adr_regs
(
   input  wire logic       clk_sys,
   input  wire logic       srst,
   input  wire logic       ce,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   input  wire logic       mute_i,
   input  wire logic       ev_diag_fault,
   input  wire logic       ev_overcurrent,
   input  wire logic       ev_undervolt,
   input  wire logic       ev_overvolt,
   input  wire logic       ev_dc_offset,
   input  wire logic       ev_overtemp,
   input  wire logic       diag_running,
   input  wire logic       diag_start,
   input  wire logic       short_to_rail,
   input  wire logic       short_to_gnd,
   input  wire logic       open_load,
   input  wire logic       shorted_load,
   input  wire logic       hiz_fault,
   output logic            fault_n_o,
   output logic            fault_n_oe,
   output logic            switch_en,
   output logic [1:0]      gain_sel,
   output logic            freq_sel,
   output logic [2:0]      limiter_sel
);
   logic             scl_s;
   logic             scl_rise;
   logic             scl_fall;
   logic             sda_s;
   logic             sda_rise;
   logic             sda_fall;
   logic             mute_s;
   adr_pkg::adr_state_t st_r;
   adr_pkg::adr_state_t st_nxt;
   adr_pkg::adr_state_t after_ack_r;
   logic [7:0]       sh_r;
   logic [3:0]       cnt_r;
   logic [7:0]       ptr_r;
   logic             sub_done_r;
   logic             rd_r;
   logic [7:0]       ctrl_r;
   logic [7:0]       sts_r;
   logic             open_r;
   logic             sda_drv_r;
   logic             fault_clr;
   logic [5:0]       fault_q;
   logic [7:0]       fault_reg;
   logic [7:0]       rd_data;
   logic             start_c;
   logic             stop_c;
   logic [7:0]       sh_in;

   adr_sync u_scl (.clk_sys(clk_sys), .srst(srst), .ce(ce), .din(scl_i),
                   .dout(scl_s), .rise(scl_rise), .fall(scl_fall));
   adr_sync u_sda (.clk_sys(clk_sys), .srst(srst), .ce(ce), .din(sda_i),
                   .dout(sda_s), .rise(sda_rise), .fall(sda_fall));
   adr_sync u_mut (.clk_sys(clk_sys), .srst(srst), .ce(ce), .din(mute_i),
                   .dout(mute_s), .rise(), .fall());

   // register read mux
   function automatic logic [7:0] reg_sel(input logic [7:0] a, input logic [7:0] f,
                                          input logic [7:0] s, input logic [7:0] c);
      case (a)
         adr_pkg::OFS_FAULT:   reg_sel = f;
         adr_pkg::OFS_STATUS:  reg_sel = s;
         adr_pkg::OFS_CONTROL: reg_sel = c;
         default:              reg_sel = 8'h00;
      endcase
   endfunction

   // fault latch: clears after a read of it completes
   adr_fault_latch #(.W(6)) u_flt
   (
      .clk_sys (clk_sys),
      .srst    (srst),
      .ce      (ce),
      .ev      ({ev_overtemp, ev_dc_offset, ev_overvolt,
                 ev_undervolt, ev_overcurrent, ev_diag_fault}),
      .clr     (fault_clr),
      .q       (fault_q)
   );
   assign fault_reg = {fault_q, 2'b00};

   assign start_c = scl_s & sda_fall;
   assign stop_c  = scl_s & sda_rise;
   assign sh_in   = {sh_r[6:0], sda_s};
   assign rd_data = reg_sel(ptr_r, fault_reg, sts_r, ctrl_r);
   // pointer has already stepped past the byte just read
   assign fault_clr = ce & (st_r == adr_pkg::ADR_RACK) & scl_rise
                      & (ptr_r == adr_pkg::OFS_FAULT + 8'h01);

   // open-load indication held until the next diagnostic cycle begins
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         open_r <= 1'b0;
      else if (ce)
         open_r <= open_load | (open_r & ~diag_start);
   end

   // live status: one sampling stage, except open load held in open_r and mute taken after the synchroniser
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         sts_r <= adr_pkg::RST_STATUS;
      else if (ce)
      begin
         sts_r[0] <= short_to_rail;
         sts_r[1] <= short_to_gnd;
         sts_r[2] <= open_r;
         sts_r[3] <= shorted_load;
         sts_r[adr_pkg::ST_FAULT] <= hiz_fault;
         sts_r[adr_pkg::ST_DIAG]  <= diag_running;
         sts_r[adr_pkg::ST_MUTE]  <= mute_s & ~hiz_fault & ~diag_running;
         sts_r[adr_pkg::ST_PLAY]  <= ~mute_s & ~hiz_fault & ~diag_running;
      end
   end

   // serial state machine, bit count on scl rise, shift out on scl fall
   always_comb
   begin
      st_nxt = st_r;
      if (start_c)
         st_nxt = adr_pkg::ADR_DEV;
      else if (stop_c)
         st_nxt = adr_pkg::ADR_IDLE;
      else if (scl_fall)
      begin
         case (st_r)
            adr_pkg::ADR_DEV,
            adr_pkg::ADR_SUB,
            adr_pkg::ADR_WDAT:
               if (cnt_r == 4'd8)
                  st_nxt = (st_r == adr_pkg::ADR_DEV &&
                            sh_r[7:1] != adr_pkg::I2C_DEV_ADDR) ?
                           adr_pkg::ADR_SKIP : adr_pkg::ADR_ACK;
            adr_pkg::ADR_ACK:
               st_nxt = after_ack_r;
            adr_pkg::ADR_RDAT:
               if (cnt_r == 4'd8)
                  st_nxt = adr_pkg::ADR_RACK;
            adr_pkg::ADR_RACK:
               st_nxt = sda_drv_r ? adr_pkg::ADR_SKIP : adr_pkg::ADR_RDAT;
            default: st_nxt = st_r;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         st_r        <= adr_pkg::ADR_IDLE;
         after_ack_r <= adr_pkg::ADR_IDLE;
         sh_r        <= 8'h00;
         cnt_r       <= 4'd0;
         ptr_r       <= 8'h00;
         sub_done_r  <= 1'b0;
         rd_r        <= 1'b0;
         ctrl_r      <= adr_pkg::RST_CONTROL;
         sda_drv_r   <= 1'b0;
      end
      else if (ce)
      begin
         st_r <= st_nxt;
         if (start_c)
         begin
            cnt_r      <= 4'd0;
            sub_done_r <= 1'b0;
         end
         else if (scl_rise)
         begin
            if (st_r == adr_pkg::ADR_RACK)
               sda_drv_r <= sda_s; // master nack seen
            else
            begin
               // read shifter moves on scl fall only, never while scl high
               if (st_r != adr_pkg::ADR_RDAT)
                  sh_r <= sh_in;
               cnt_r <= cnt_r + 4'd1;
            end
         end
         else if (scl_fall)
         begin
            sda_drv_r <= 1'b0;
            case (st_r)
               adr_pkg::ADR_DEV:
                  if (cnt_r == 4'd8)
                  begin
                     rd_r        <= sh_r[0];
                     after_ack_r <= sh_r[0] ? adr_pkg::ADR_RDAT : adr_pkg::ADR_SUB;
                     sda_drv_r   <= (sh_r[7:1] == adr_pkg::I2C_DEV_ADDR);
                  end
               adr_pkg::ADR_SUB:
                  if (cnt_r == 4'd8)
                  begin
                     ptr_r       <= sh_r;
                     sub_done_r  <= 1'b1;
                     after_ack_r <= adr_pkg::ADR_WDAT;
                     sda_drv_r   <= 1'b1;
                  end
               adr_pkg::ADR_WDAT:
                  if (cnt_r == 4'd8)
                  begin
                     if (ptr_r == adr_pkg::OFS_CONTROL)
                        ctrl_r <= sh_r & adr_pkg::CTRL_WR_MSK;
                     ptr_r     <= ptr_r + 8'h01;
                     sda_drv_r <= 1'b1;
                  end
               adr_pkg::ADR_ACK:
               begin
                  cnt_r <= 4'd0;
                  if (after_ack_r == adr_pkg::ADR_RDAT)
                     sh_r <= rd_data;
               end
               adr_pkg::ADR_RDAT:
                  if (cnt_r == 4'd8)
                     ptr_r <= ptr_r + 8'h01;
                  else
                     sh_r <= {sh_r[6:0], 1'b0};
               adr_pkg::ADR_RACK:
               begin
                  cnt_r <= 4'd0;
                  sh_r  <= rd_data;
               end
               default: cnt_r <= cnt_r;
            endcase
         end
      end
   end

   // read data from shifter msb, held through scl high up to the next fall
   logic rd_bit;
   assign rd_bit = (st_r == adr_pkg::ADR_RDAT) & ~sh_r[7];
   assign sda_o  = 1'b0;
   assign sda_oe = ((st_r == adr_pkg::ADR_ACK) & sda_drv_r) | rd_bit;

   assign fault_n_o  = 1'b0;
   assign fault_n_oe = hiz_fault;
   assign switch_en  = ~mute_s & ~hiz_fault & ~diag_running;
   assign gain_sel    = ctrl_r[adr_pkg::GAIN_LSB +: 2];
   assign freq_sel    = ctrl_r[adr_pkg::BIT_FREQ];
   assign limiter_sel = ctrl_r[adr_pkg::LIM_LSB +: 3];

   // checks
   ctrl_reset_a: assert property (@(posedge clk_sys) $past(srst) && !srst |->
      ctrl_r == adr_pkg::RST_CONTROL && sts_r == adr_pkg::RST_STATUS
      && fault_reg == adr_pkg::RST_FAULT)
      else $error("register reset value wrong");
   rsvd_ctrl_a: assert property (@(posedge clk_sys) disable iff (srst)
      ctrl_r[2:1] == 2'b00)
      else $error("reserved control bits set");
   rsvd_fault_a: assert property (@(posedge clk_sys) disable iff (srst)
      fault_reg[1:0] == 2'b00)
      else $error("reserved fault bits set");
   oc_latch_a: assert property (@(posedge clk_sys) disable iff (srst)
      ce && ev_overcurrent |=> fault_reg[3])
      else $error("overcurrent not latched");
   ot_latch_a: assert property (@(posedge clk_sys) disable iff (srst)
      ce && ev_overtemp |=> fault_reg[7])
      else $error("overtemperature not latched");
   uv_latch_a: assert property (@(posedge clk_sys) disable iff (srst)
      ce && ev_undervolt |=> fault_reg[4])
      else $error("undervoltage not latched");
   fault_pin_a: assert property (@(posedge clk_sys) fault_n_oe == hiz_fault)
      else $error("fault pin mismatch");
   mute_stop_a: assert property (@(posedge clk_sys) disable iff (srst)
      mute_s |-> !switch_en)
      else $error("switching while muted");
   short_rail_a: assert property (@(posedge clk_sys) disable iff (srst)
      ce && short_to_rail |=> sts_r[0])
      else $error("rail short not shown");
   incr_read_a: assert property (@(posedge clk_sys) disable iff (srst)
      ce && scl_fall && !start_c && !stop_c && st_r == adr_pkg::ADR_RDAT
      && cnt_r == 4'd8 |=> ptr_r == $past(ptr_r) + 8'h01)
      else $error("read pointer not incremented");
   cv_write_c: cover property (@(posedge clk_sys) st_r == adr_pkg::ADR_WDAT);
   cv_read_c:  cover property (@(posedge clk_sys) st_r == adr_pkg::ADR_RACK);
   cv_fault_c: cover property (@(posedge clk_sys) fault_clr);
endmodule

// File: bench/adr_i2c_master.sv
// two-wire bus master model driving clock and open-drain data
`timescale 1ns/1ps
module adr_i2c_master
(
   input  wire logic clk_sys,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_oe
);
   // bus idles released, clock stands high between frames
   initial
   begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // data moves only while clock low; 8 cycles low, 8 high
   task automatic bitx(input logic v, output logic s);
      sda_oe <= !v;
      hold(4);
      scl <= 1'b1;
      hold(4);
      @(negedge clk_sys);
      s = sda;
      hold(4);
      scl <= 1'b0;
      hold(4);
   endtask
   task automatic start();
      sda_oe <= 1'b0;
      hold(4);
      scl <= 1'b1;
      hold(4);
      sda_oe <= 1'b1;
      hold(4);
      scl <= 1'b0;
      hold(4);
   endtask
   task automatic stop();
      sda_oe <= 1'b1;
      hold(4);
      scl <= 1'b1;
      hold(4);
      sda_oe <= 1'b0;
      hold(8);
   endtask
   // eight bits msb first, ninth bit b9 released or driven by master
   task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] q,
                       output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bitx(d[i], s);
         q[i] = s;
      end
      bitx(b9, s);
      ack = !s;
   endtask
endmodule

// File: bench/adr_regs_tb.sv
// self-checking bench for the amplifier diagnostic register bank
`timescale 1ns/1ps
module adr_regs_tb;
   localparam logic [7:0] WR_DEV = {adr_pkg::I2C_DEV_ADDR, 1'b0};
   logic       clk_sys      = 1'b0;
   logic       srst         = 1'b1;
   logic       mute_i       = 1'b0;
   logic [5:0] ev           = 6'h00;
   logic [3:0] ld           = 4'h0;
   logic       diag_running = 1'b0;
   logic       diag_start   = 1'b0;
   logic       hiz          = 1'b0;
   logic       scl;
   logic       m_oe;
   logic       sda_o;
   logic       sda_oe;
   logic       fault_n_o;
   logic       fault_n_oe;
   logic       switch_en;
   logic [1:0] gain_sel;
   logic       freq_sel;
   logic [2:0] limiter_sel;
   logic [7:0] rb [4];
   int         n_mismatch   = 0;
   int         num_checks   = 0;
   int         cycles       = 0;
   wire        sda          = (sda_oe ? sda_o : 1'b1) & !m_oe;

   always #5 clk_sys = ~clk_sys;

   adr_i2c_master u_m (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_oe(m_oe));

   adr_regs dut
   (
      .clk_sys(clk_sys), .srst(srst), .ce(1'b1), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .mute_i(mute_i),
      .ev_diag_fault(ev[0]), .ev_overcurrent(ev[1]), .ev_undervolt(ev[2]),
      .ev_overvolt(ev[3]), .ev_dc_offset(ev[4]), .ev_overtemp(ev[5]),
      .diag_running(diag_running), .diag_start(diag_start),
      .short_to_rail(ld[0]), .short_to_gnd(ld[1]), .open_load(ld[2]),
      .shorted_load(ld[3]), .hiz_fault(hiz), .fault_n_o(fault_n_o),
      .fault_n_oe(fault_n_oe), .switch_en(switch_en), .gain_sel(gain_sel),
      .freq_sel(freq_sel), .limiter_sel(limiter_sel)
   );

   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] dev, input logic [7:0] sub, input logic [7:0] d,
                     output logic ack);
      logic [7:0] q;
      logic       a1;
      logic       a2;
      logic       a3;
      u_m.start();
      u_m.xfer(dev, 1'b1, q, a1);
      u_m.xfer(sub, 1'b1, q, a2);
      u_m.xfer(d, 1'b1, q, a3);
      u_m.stop();
      ack = a1 & a2 & a3;
   endtask
   // pointer write, repeated start, n bytes acked except the last
   task automatic rd(input logic [7:0] sub, input int n);
      logic [7:0] q;
      logic       a;
      u_m.start();
      u_m.xfer(WR_DEV, 1'b1, q, a);
      u_m.xfer(sub, 1'b1, q, a);
      u_m.start();
      u_m.xfer(WR_DEV | 8'h01, 1'b1, q, a);
      for (int i = 0; i < n; i++)
         u_m.xfer(8'hff, i == n - 1, rb[i], a);
      u_m.stop();
   endtask
   task automatic pins(input logic [7:0] exp);
      repeat (8) @(posedge clk_sys);
      chk({6'h00, fault_n_oe, switch_en}, exp);
   endtask

   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         n_mismatch++;
         stop_test();
      end
   end

   initial
   begin
      logic [2:0] k;
      logic [7:0] v;
      logic       a;
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk({2'b00, gain_sel, limiter_sel, freq_sel}, 8'h1e);
      rd(8'h01, 3);
      chk(rb[0], 8'h00);
      chk(rb[1], 8'h80);
      chk(rb[2], 8'h78);
      // every gain and limiter code, both frequencies, reserved bits set
      for (int i = 0; i < 8; i++)
      begin
         k = 3'(i);
         v = {k[1:0], k, k};
         wr(WR_DEV, adr_pkg::OFS_CONTROL, v, a);
         chk({7'h00, a}, 8'h01);
         rd(adr_pkg::OFS_CONTROL, 1);
         chk(rb[0], v & 8'hf9);
         chk({2'b00, gain_sel, limiter_sel, freq_sel}, {2'b00, k[1:0], k, k[0]});
      end
      wr(WR_DEV, 8'h01, 8'hff, a);
      wr(WR_DEV, 8'h02, 8'hff, a);
      wr(8'h5a, 8'h03, 8'h00, a);
      chk({7'h00, a}, 8'h00);
      rd(8'h01, 3);
      chk(rb[0], 8'h00);
      chk(rb[1], 8'h80);
      chk(rb[2], 8'hf9);
      for (int j = 0; j < 6; j++)
      begin
         ev <= 6'h01 << j;
         @(posedge clk_sys);
         ev <= 6'h00;
         rd(8'h01, 1);
         chk(rb[0], 8'h04 << j);
      end
      rd(8'h01, 1);
      chk(rb[0], 8'h00);
      mute_i <= 1'b1;
      ld <= 4'hf;
      @(posedge clk_sys);
      ld <= 4'hb;
      pins(8'h00);
      rd(8'h02, 1);
      chk(rb[0], 8'h4f);
      diag_start <= 1'b1;
      ld <= 4'h0;
      mute_i <= 1'b0;
      @(posedge clk_sys);
      diag_start <= 1'b0;
      diag_running <= 1'b1;
      pins(8'h00);
      rd(8'h02, 1);
      chk(rb[0], 8'h20);
      diag_running <= 1'b0;
      hiz <= 1'b1;
      pins(8'h02);
      hiz <= 1'b0;
      pins(8'h01);
      stop_test();
   end
endmodule
